/* File: spp_pkg.sv */
// package for the shared-pin parallel port: widths, selectors, reset values, carriers
package spp_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int unsigned PORT_WIDTH = 16;
  localparam int unsigned SYNC_STAGES = 2;

  // ---------------------------------------------------------------------------
  // register selector codes (no bus: a local access port picks the register)
  // ---------------------------------------------------------------------------
  localparam logic [1:0] SEL_DIRECTION = 2'h0;
  localparam logic [1:0] SEL_LATCH     = 2'h1;
  localparam logic [1:0] SEL_PIN_LEVEL = 2'h2;

  // ---------------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------------
  localparam logic [PORT_WIDTH-1:0] DIRECTION_RESET = 16'hffff;
  localparam logic [PORT_WIDTH-1:0] LATCH_RESET     = 16'h0000;
  localparam logic [PORT_WIDTH-1:0] IMPL_MASK_DEF   = 16'hffff;
  localparam logic [PORT_WIDTH-1:0] INPUT_ONLY_DEF  = 16'h0000;

  // ---------------------------------------------------------------------------
  // access state machine
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    SPP_IDLE = 2'b01,
    SPP_DONE = 2'b10
  } spp_state_type;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic                  write;
    logic [1:0]            sel;
    logic [PORT_WIDTH-1:0] wdata;
  } spp_req_type;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] enable;
    logic [PORT_WIDTH-1:0] drive;
    logic [PORT_WIDTH-1:0] data;
  } spp_periph_type;

  typedef struct packed {
    logic [PORT_WIDTH-1:0] data;
    logic [PORT_WIDTH-1:0] oe;
  } spp_pad_out_type;

endpackage

/* File: spp_sync.sv */
// two-stage synchroniser for the pad inputs, one per bit
`timescale 1ns/1ps
module spp_sync #(
  parameter int unsigned WIDTH = 16
) (
  // clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // ---------------------------------------------------------------------------
  // per-bit flops; stage one feeds stage two only
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          stage1_reg[g] <= 1'b0;
          stage2_reg[g] <= 1'b0;
        end else begin
          stage1_reg[g] <= async_in[g];
          stage2_reg[g] <= stage1_reg[g];
        end
      end
    end
  endgenerate

  assign sync_out = stage2_reg;

endmodule

/* File: spp_port.sv */
// shared-pin parallel port: direction, latch, pin read and peripheral muxing
//
// Overview of operation
// - an enabled peripheral that is actively driving owns pin output data and control over the port
// - port output does not loop back into a sharing peripheral's input while the port drives, but can reach it for up to three cycles after release
// - peripheral actively driving: port driver off, pin level still readable
// - peripheral enabled but idle: port may drive the pin
// - direction bit 1 means input, 0 means output
// - after any reset every implemented direction bit is input
// - latch read returns latch contents; latch write updates latch
// - pin-level read returns pins; pin-level write updates the latch
// - unimplemented bits: latch, direction and pin level read zero
// - pins shared only with input functions are dedicated port pins
`timescale 1ns/1ps
module spp_port #(
  parameter logic [spp_pkg::PORT_WIDTH-1:0] IMPL_MASK  = spp_pkg::IMPL_MASK_DEF,
  parameter logic [spp_pkg::PORT_WIDTH-1:0] INPUT_ONLY = spp_pkg::INPUT_ONLY_DEF
) (
  // clock and reset
  input  wire logic                               mclk_in,
  input  wire logic                               reset_n_in,
  // register access port
  input  wire logic                               req_valid_in,
  input  wire spp_pkg::spp_req_type               req_in,
  output logic                                    ack_out,
  output logic [spp_pkg::PORT_WIDTH-1:0]          rdata_out,
  // peripherals sharing the pins
  input  wire spp_pkg::spp_periph_type            periph_in,
  output logic [spp_pkg::PORT_WIDTH-1:0]          periph_pin_out,
  // pads
  input  wire logic [spp_pkg::PORT_WIDTH-1:0]     pad_in,
  output spp_pkg::spp_pad_out_type                pad_out,
  // status
  output logic [spp_pkg::PORT_WIDTH-1:0]          pin_direction_out,
  output logic [spp_pkg::PORT_WIDTH-1:0]          output_latch_out
);

  localparam int unsigned W = spp_pkg::PORT_WIDTH;

  // stored state
  logic [W-1:0]               pin_direction_reg;
  logic [W-1:0]               output_latch_reg;
  logic [W-1:0]               rdata_reg;
  logic [W-1:0]               rdata_next;
  spp_pkg::spp_state_type     state_reg;
  spp_pkg::spp_state_type     state_next;

  // access decode
  logic                       take;
  logic                       wr_direction;
  logic                       wr_latch;
  logic                       rd_take;
  logic [W-1:0]               wdata_masked;

  // pin levels and readable views
  logic [W-1:0]               pin_level_reg;
  logic [W-1:0]               dir_view;
  logic [W-1:0]               latch_view;
  logic [W-1:0]               pin_view;

  // pin ownership and pad drive
  logic [W-1:0]               shared_pins;
  logic [W-1:0]               periph_enabled;
  logic [W-1:0]               periph_idle;
  logic [W-1:0]               periph_owns;
  logic [W-1:0]               port_drives;
  logic [W-1:0]               pad_oe_next;
  logic [W-1:0]               pad_oe_reg;
  logic [W-1:0]               pad_data_next;
  logic [W-1:0]               pad_data_reg;
  logic [W-1:0]               periph_pin_next;
  logic [W-1:0]               periph_pin_reg;
  genvar                      g;

  // ---------------------------------------------------------------------------
  // pin sampling
  // ---------------------------------------------------------------------------
  // a pin that moves near the clock edge must not reach two readers differently
  spp_sync #(
    .WIDTH (W)
  ) u_sync (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .async_in   (pad_in),
    .sync_out   (pin_level_reg)
  );

  // ---------------------------------------------------------------------------
  // access handshake: one request per two cycles, ack for one cycle
  // ---------------------------------------------------------------------------
  assign take = req_valid_in && (state_reg == spp_pkg::SPP_IDLE);

  always_comb begin
    case (state_reg)
      spp_pkg::SPP_IDLE: begin
        if (take) begin
          state_next = spp_pkg::SPP_DONE;
        end else begin
          state_next = spp_pkg::SPP_IDLE;
        end
      end
      spp_pkg::SPP_DONE: begin
        state_next = spp_pkg::SPP_IDLE;
      end
      default: begin
        state_next = spp_pkg::SPP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      state_reg <= spp_pkg::SPP_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // a request held through the ack cycle is refused there and taken one cycle later
  assign ack_out = (state_reg == spp_pkg::SPP_DONE);

  // ---------------------------------------------------------------------------
  // access decode: a write through the pin-level selector lands in the latch
  // ---------------------------------------------------------------------------
  assign wdata_masked = req_in.wdata & IMPL_MASK;

  always_comb begin
    wr_direction = 1'b0;
    wr_latch     = 1'b0;
    rd_take      = 1'b0;
    if (take) begin
      if (req_in.write) begin
        case (req_in.sel)
          spp_pkg::SEL_DIRECTION: begin
            wr_direction = 1'b1;
          end
          spp_pkg::SEL_LATCH: begin
            wr_latch = 1'b1;
          end
          spp_pkg::SEL_PIN_LEVEL: begin
            wr_latch = 1'b1;
          end
          default: begin
            // unmapped selector: the write is dropped
            wr_latch = 1'b0;
          end
        endcase
      end else begin
        rd_take = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // direction register, one flop per pin; a set bit makes the pin an input
  // ---------------------------------------------------------------------------
  // the port leaves a pad undriven from reset until software clears its direction bit; a driving peripheral can still drive it
  generate
    for (g = 0; g < W; g = g + 1) begin : g_dir
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          pin_direction_reg[g] <= spp_pkg::DIRECTION_RESET[g] & IMPL_MASK[g];
        end else if (wr_direction) begin
          pin_direction_reg[g] <= wdata_masked[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // output latch, one flop per pin: written through latch or pin-level selector
  // ---------------------------------------------------------------------------
  generate
    for (g = 0; g < W; g = g + 1) begin : g_latch
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          output_latch_reg[g] <= spp_pkg::LATCH_RESET[g] & IMPL_MASK[g];
        end else if (wr_latch) begin
          output_latch_reg[g] <= wdata_masked[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // readable views: bits that do not exist read as zero on every path
  // ---------------------------------------------------------------------------
  generate
    for (g = 0; g < W; g = g + 1) begin : g_view
      assign dir_view[g]   = pin_direction_reg[g] & IMPL_MASK[g];
      assign latch_view[g] = output_latch_reg[g] & IMPL_MASK[g];
      assign pin_view[g]   = pin_level_reg[g] & IMPL_MASK[g];
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // read data, captured at the request edge and held until the next read
  // ---------------------------------------------------------------------------
  // the mux follows the selector only; the capture strobe decides what is kept
  always_comb begin
    case (req_in.sel)
      spp_pkg::SEL_DIRECTION: begin
        rdata_next = dir_view;
      end
      spp_pkg::SEL_LATCH: begin
        rdata_next = latch_view;
      end
      spp_pkg::SEL_PIN_LEVEL: begin
        rdata_next = pin_view;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (!reset_n_in) begin
      rdata_reg <= '0;
    end else if (rd_take) begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;

  // ---------------------------------------------------------------------------
  // pin classes
  // ---------------------------------------------------------------------------
  // input-only functions never compete for the driver, so their pins stay dedicated port pins
  assign shared_pins = IMPL_MASK & ~INPUT_ONLY;

  // ---------------------------------------------------------------------------
  // ownership: an actively driving peripheral wins, an idle one leaves the port
  // ---------------------------------------------------------------------------
  generate
    for (g = 0; g < W; g = g + 1) begin : g_own
      assign periph_enabled[g] = shared_pins[g] && periph_in.enable[g];
      assign periph_idle[g]    = periph_enabled[g] && !periph_in.drive[g];
      assign periph_owns[g]    = periph_enabled[g] && periph_in.drive[g];
      assign port_drives[g]    = IMPL_MASK[g] && !pin_direction_reg[g] &&
                                 (!periph_enabled[g] || periph_idle[g]);
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // output control mux
  // ---------------------------------------------------------------------------
  // registered so a pad enable never glitches while its owner changes
  generate
    for (g = 0; g < W; g = g + 1) begin : g_oe
      assign pad_oe_next[g] = periph_owns[g] | port_drives[g];
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          pad_oe_reg[g] <= 1'b0;
        end else begin
          pad_oe_reg[g] <= pad_oe_next[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // output data mux; an undriven pad carries zero so a stale latch never shows
  // ---------------------------------------------------------------------------
  generate
    for (g = 0; g < W; g = g + 1) begin : g_data
      assign pad_data_next[g] = periph_owns[g] ? periph_in.data[g] : (port_drives[g] & output_latch_reg[g]);
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          pad_data_reg[g] <= 1'b0;
        end else begin
          pad_data_reg[g] <= pad_data_next[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // peripheral input path
  // ---------------------------------------------------------------------------
  generate
    for (g = 0; g < W; g = g + 1) begin : g_back
      // while the port drives, the peripheral sees its idle zero, not the latch
      assign periph_pin_next[g] = port_drives[g] ? 1'b0 : pin_view[g];
      always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
          periph_pin_reg[g] <= 1'b0;
        end else begin
          periph_pin_reg[g] <= periph_pin_next[g];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  // pads
  assign pad_out.data      = pad_data_reg;
  assign pad_out.oe        = pad_oe_reg;

  // peripherals
  assign periph_pin_out    = periph_pin_reg;

  // status
  assign pin_direction_out = pin_direction_reg;
  assign output_latch_out  = output_latch_reg;

endmodule

/* File: spp_props.sv */
// checker for the shared-pin port
`timescale 1ns/1ps
module spp_props #(
  parameter logic [15:0] IMPL_MASK  = 16'hffff,
  parameter logic [15:0] INPUT_ONLY = 16'h0000
) (
  input wire logic                     mclk_in,
  input wire logic                     reset_n_in,
  input wire logic                     req_valid_in,
  input wire spp_pkg::spp_req_type     req_in,
  input wire logic                     ack_out,
  input wire logic [15:0]              rdata_out,
  input wire spp_pkg::spp_periph_type  periph_in,
  input wire logic [15:0]              periph_pin_out,
  input wire spp_pkg::spp_pad_out_type pad_out,
  input wire logic [15:0]              pin_direction_out,
  input wire logic [15:0]              output_latch_out
);
  // ----
  // properties
  // ----
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  logic [15:0] own;
  logic [15:0] port_drv;
  assign own = periph_in.enable & periph_in.drive & ~INPUT_ONLY;
  assign port_drv = ~pin_direction_out & ~own & IMPL_MASK;
  sequence take_s;
    req_valid_in && !ack_out;
  endsequence
  sequence wr_s(logic [1:0] s);
    take_s ##0 (req_in.write && req_in.sel == s);
  endsequence
  a_ack_pulse: assert property (ack_out |=> !ack_out) else $error("ack wider than one cycle");
  a_take_ack: assert property (take_s |=> ack_out) else $error("request not answered");
  a_ack_cause: assert property (ack_out |-> $past(req_valid_in)) else $error("ack without request");
  a_latch_write: assert property (wr_s(spp_pkg::SEL_LATCH) or wr_s(spp_pkg::SEL_PIN_LEVEL)
    |=> output_latch_out == ($past(req_in.wdata) & IMPL_MASK)) else $error("latch not written");
  a_dir_write: assert property (wr_s(spp_pkg::SEL_DIRECTION)
    |=> pin_direction_out == ($past(req_in.wdata) & IMPL_MASK)) else $error("direction not written");
  a_dir_reset: assert property ($rose(reset_n_in) |-> pad_out.oe == 16'h0000
    && pin_direction_out == (spp_pkg::DIRECTION_RESET & IMPL_MASK)) else $error("reset state wrong");
  a_drive_rule: assert property ($past(reset_n_in) |-> (pad_out.oe & IMPL_MASK)
    == ((~$past(pin_direction_out) | $past(own)) & IMPL_MASK)) else $error("pad enable wrong");
  a_data_mux: assert property ($past(reset_n_in) |-> (pad_out.data & pad_out.oe & IMPL_MASK)
    == ((($past(own) & $past(periph_in.data)) | (~$past(own) & $past(output_latch_out)))
    & pad_out.oe & IMPL_MASK)) else $error("pad data wrong");
  a_unimpl_zero: assert property (((pin_direction_out | output_latch_out) & ~IMPL_MASK) == 0
    && (!ack_out || (rdata_out & ~IMPL_MASK) == 0)) else $error("unimplemented bit set");
  a_no_loop: assert property ($stable(port_drv) && $past(port_drv) == $past(port_drv, 2)
    |-> (periph_pin_out & port_drv) == 16'h0000) else $error("port output loops back");
endmodule
bind spp_port spp_props #(.IMPL_MASK(IMPL_MASK), .INPUT_ONLY(INPUT_ONLY)) i_props (
  .mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid_in), .req_in(req_in),
  .ack_out(ack_out), .rdata_out(rdata_out), .periph_in(periph_in), .periph_pin_out(periph_pin_out),
  .pad_out(pad_out), .pin_direction_out(pin_direction_out), .output_latch_out(output_latch_out));

/* File: spp_pins.sv */
// pad model: far-side pin levels merged with the pad drivers
`timescale 1ns/1ps
module spp_pins (
  input  wire spp_pkg::spp_pad_out_type pad_drv_in,
  input  wire logic [15:0]              ext_in,
  output logic [15:0]                   pin_out
);
  // a driven pin follows its driver, an undriven one the far side
  assign pin_out = (pad_drv_in.oe & pad_drv_in.data) | (~pad_drv_in.oe & ext_in);
endmodule

/* File: testbench.sv */
// self-checking bench for the shared-pin port
`timescale 1ns/1ps
module testbench;
  // ----
  // bench
  // ----
  localparam logic [15:0] MASK = 16'h7fff;
  localparam logic [15:0] INONLY = 16'h0003;
  logic mclk_in = 0, reset_n_in = 0, req_valid_in = 0, ack_out;
  spp_pkg::spp_req_type req_in = '0;
  spp_pkg::spp_periph_type periph_in = '0;
  spp_pkg::spp_pad_out_type pad_out;
  logic [15:0] rdata_out, periph_pin_out, pad_in, pin_direction_out, output_latch_out;
  logic [15:0] ext = '0, dir_m, lat_m, rd, own, oe_m, pin_m, exp_rd;
  int err_count = 0, checks = 0, cyc = 0;
  always #10 mclk_in = ~mclk_in;
  spp_port #(.IMPL_MASK(MASK), .INPUT_ONLY(INONLY)) i_spp_port (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .req_valid_in(req_valid_in), .req_in(req_in), .ack_out(ack_out),
    .rdata_out(rdata_out), .periph_in(periph_in), .periph_pin_out(periph_pin_out), .pad_in(pad_in),
    .pad_out(pad_out), .pin_direction_out(pin_direction_out), .output_latch_out(output_latch_out));
  spp_pins i_spp_pins (.pad_drv_in(pad_out), .ext_in(ext), .pin_out(pad_in));
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge mclk_in);
    #1 reset_n_in = 0;
    periph_in = '0;
    repeat (5) @(posedge mclk_in);
    #1 reset_n_in = 1;
    dir_m = 16'hffff & MASK;
    lat_m = '0;
  endtask
  // valid is held until ack shows, so a held request is never taken twice
  task automatic access(logic w, logic [1:0] s, logic [15:0] d);
    int n;
    @(posedge mclk_in);
    #1 req_in = '{w, s, d};
    req_valid_in = 1;
    for (n = 0; n < 8 && ack_out !== 1'b1; n++) begin
      @(posedge mclk_in);
      #1;
    end
    rd = rdata_out;
    req_valid_in = 0;
    check("ack", {15'h0, ack_out}, 16'h0001);
  endtask
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    logic w;
    logic [1:0] s;
    logic [15:0] d;
    void'($urandom(77));
    do_reset();
    for (int t = 0; t < 40; t++) begin
      if (t == 20) do_reset();
      periph_in = '{16'($urandom), 16'($urandom), 16'($urandom)};
      ext = 16'($urandom);
      repeat (4) @(posedge mclk_in);
      #1;
      own = periph_in.enable & periph_in.drive & ~INONLY;
      oe_m = (~dir_m | own) & MASK;
      pin_m = (oe_m & ((own & periph_in.data) | (~own & lat_m))) | (~oe_m & ext);
      check("oe", pad_out.oe & MASK, oe_m);
      check("data", pad_out.data & oe_m, pin_m & oe_m);
      check("loop", periph_pin_out & MASK, pin_m & ~(~dir_m & ~own) & MASK);
      check("dir", pin_direction_out, dir_m);
      check("lat", output_latch_out, lat_m);
      w = 1'($urandom);
      s = 2'($urandom);
      d = 16'($urandom);
      access(w, s, d);
      exp_rd = s == 2'h0 ? dir_m : s == 2'h1 ? lat_m : s == 2'h2 ? pin_m & MASK : 16'h0000;
      if (!w) check("rdata", rd, exp_rd);
      if (w && s == 2'h0) dir_m = d & MASK;
      if (w && (s == 2'h1 || s == 2'h2)) lat_m = d & MASK;
      $display("test %0d done", t);
    end
    close_out();
  end
endmodule
